// *** twf_fetch.sv ***
// Instruction fetch sequencer that pairs two-word instructions.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Memory is byte addressed; instructions span one or two 16-bit words.
// - Each word sits low byte at even address, high byte at next odd.
// - Counter steps two bytes per word; its bit zero is always zero.
// - Absolute goto and call load their word target into counter bits 20:1.
// - Branch offsets count words and are doubled to bytes before adding.
// - Goto, call, file move and pointer load each take two words.
// - Second word carries prefix 1111 and a twelve-bit literal operand.
// - A 1111-prefixed word not consumed as operand decodes as no-op.
// - An operand word right after its first word supplies the literal.
// - An operand word reached alone after a skip executes as no-op.
module twf_fetch (
  input wire logic ref_clk, // Core clock, 10 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  output logic pm_req, // Program memory read request, held to pm_valid.
  output logic [twf_pkg::PC_W-1:0] pm_addr, // Byte address of the word.
  input wire logic [twf_pkg::WORD_W-1:0] pm_data, // Word read from memory.
  input wire logic pm_valid, // Word on pm_data is valid this cycle.
  input wire logic skip_req, // Execute side asks to skip the next word.
  input wire logic core_ready, // Execute side takes the offered op.
  output logic op_valid, // A decoded op is offered.
  output twf_pkg::twf_op_t op, // The decoded op.
  output logic [twf_pkg::PC_W-1:0] pc, // Byte address of the next fetch.
  output logic two_word_pending // First word held, operand awaited.
);

  twf_pkg::twf_state_t state;
  logic [twf_pkg::PC_W-2:0] pc_word;
  logic skip_pend;
  logic [twf_pkg::WORD_W-1:0] first_word;
  logic [twf_pkg::PC_W-1:0] first_addr;
  twf_pkg::twf_kind_t first_kind;
  logic capture;
  logic cls_operand;
  logic cls_two_word;
  twf_pkg::twf_kind_t cls_kind;
  logic [twf_pkg::PC_W-1:0] cls_ofs;
  logic [twf_pkg::PC_W-1:0] pc_byte;
  logic [twf_pkg::PC_W-1:0] next_pc;
  logic next_emit;
  logic next_pend;
  twf_pkg::twf_op_t next_op;

  // The counter keeps only bits 20:1, so bit zero cannot drift off zero.
  assign pc_byte = {pc_word, 1'b0};

  // A word is taken when memory answers during the wait state.
  assign capture = (state == twf_pkg::ST_WAIT) && pm_valid;

  twf_word_class u_class (
    .word(pm_data),
    .is_operand(cls_operand),
    .is_two_word(cls_two_word),
    .kind(cls_kind),
    .branch_ofs(cls_ofs)
  );

  // Decode of the captured word against the pending and skip state.
  always_comb begin
    next_pc = pc_byte + twf_pkg::WORD_BYTES;
    next_emit = 1'b0;
    next_pend = 1'b0;
    next_op.kind = cls_kind;
    next_op.first = pm_data;
    next_op.literal = pm_data[twf_pkg::LIT_W-1:0];
    next_op.addr = pc_byte;
    if (skip_pend) begin
      // A skipped first word leaves its operand word to arrive alone.
      next_emit = 1'b0;
    end else if (two_word_pending && cls_operand) begin
      next_emit = 1'b1;
      next_op.kind = first_kind;
      next_op.first = first_word;
      next_op.addr = first_addr;
      next_op.literal = pm_data[twf_pkg::LIT_W-1:0];
      if ((first_kind == twf_pkg::K_GOTO) ||
          (first_kind == twf_pkg::K_CALL)) begin
        // Word target goes to bits 20:1, giving an even byte address.
        next_pc = {pm_data[twf_pkg::LIT_W-1:0],
                   first_word[twf_pkg::BYTE_W-1:0], 1'b0};
      end
    end else if (cls_operand) begin
      next_emit = 1'b1;
      next_op.kind = twf_pkg::K_NOP_OPERAND;
    end else if (cls_two_word) begin
      next_pend = 1'b1;
    end else if (cls_kind == twf_pkg::K_BRANCH) begin
      next_emit = 1'b1;
      next_pc = pc_byte + twf_pkg::WORD_BYTES + cls_ofs;
    end else begin
      next_emit = 1'b1;
    end
  end

  // Sequencer: fetch, wait for the word, offer the op until taken.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= twf_pkg::ST_FETCH;
    end else begin
      unique case (state)
        twf_pkg::ST_FETCH: begin
          state <= twf_pkg::ST_WAIT;
        end
        twf_pkg::ST_WAIT: begin
          if (pm_valid) begin
            state <= next_emit ? twf_pkg::ST_ISSUE : twf_pkg::ST_FETCH;
          end
        end
        twf_pkg::ST_ISSUE: begin
          if (core_ready) begin
            state <= twf_pkg::ST_FETCH;
          end
        end
        default: begin
          state <= twf_pkg::ST_FETCH;
        end
      endcase
    end
  end

  // Program counter in word units; it moves once per captured word.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_word <= twf_pkg::PC_RESET[twf_pkg::PC_W-1:1];
    end else if (capture) begin
      pc_word <= next_pc[twf_pkg::PC_W-1:1];
    end
  end

  // Memory request: one word per request, even byte address only.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pm_req <= 1'b0;
      pm_addr <= twf_pkg::PC_RESET;
    end else if (state == twf_pkg::ST_FETCH) begin
      pm_req <= 1'b1;
      pm_addr <= pc_byte;
    end else if (capture) begin
      pm_req <= 1'b0;
    end
  end

  // Pending first word; any captured word ends or restarts the pairing.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      two_word_pending <= 1'b0;
      first_word <= '0;
      first_addr <= twf_pkg::PC_RESET;
      first_kind <= twf_pkg::K_SINGLE;
    end else if (capture) begin
      two_word_pending <= next_pend;
      if (next_pend) begin
        first_word <= pm_data;
        first_addr <= pc_byte;
        first_kind <= cls_kind;
      end
    end
  end

  // Skip request: a new request in the drop cycle wins over the clear.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      skip_pend <= 1'b0;
    end else if (skip_req) begin
      skip_pend <= 1'b1;
    end else if (capture) begin
      skip_pend <= 1'b0;
    end
  end

  // Offered op is registered so the execute side sees stable fields.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_valid <= 1'b0;
      op <= '0;
    end else if (capture && next_emit) begin
      op_valid <= 1'b1;
      op <= next_op;
    end else if ((state == twf_pkg::ST_ISSUE) && core_ready) begin
      op_valid <= 1'b0;
    end
  end

  // Counter copy for the outside; bit zero stays zero.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= twf_pkg::PC_RESET;
    end else if (capture) begin
      pc <= {next_pc[twf_pkg::PC_W-1:1], 1'b0};
    end
  end

endmodule : twf_fetch
`default_nettype wire

// *** twf_pkg.sv ***
// Shared constants, encodings and carrier types of the two-word fetch block.
package twf_pkg;

  // Widths of the byte address, the instruction word, its literal field, a byte and the branch offset.
  localparam int PC_W = 21;
  localparam int WORD_W = 16;
  localparam int LIT_W = 12;
  localparam int BYTE_W = 8;
  localparam int BRA_OFS_W = 11;

  // Byte address after reset and the byte step of one instruction word.
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] WORD_BYTES = 21'h000002;

  // Upper nibble that marks an operand word (and its stand-alone no-op).
  localparam logic [3:0] OPERAND_PREFIX = 4'hF;

  // Opcode fields of the first word; widths match the field they meet.
  localparam logic [7:0] GOTO_OPC = 8'hEF;
  localparam logic [6:0] CALL_OPC = 7'h76;
  localparam logic [3:0] FILE_MOVE_OPC = 4'hC;
  localparam logic [7:0] PTR_LOAD_OPC = 8'hEE;
  localparam logic [4:0] BRA_OPC = 5'h1A;

  // Kind of a decoded instruction as handed to the execute side.
  typedef enum logic [2:0] {
    K_SINGLE = 3'h0,
    K_GOTO = 3'h1,
    K_CALL = 3'h2,
    K_FILE_MOVE = 3'h3,
    K_PTR_LOAD = 3'h4,
    K_BRANCH = 3'h5,
    K_NOP_OPERAND = 3'h6
  } twf_kind_t;

  // Fetch sequencer states, Gray coded along fetch, wait, issue.
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_WAIT = 2'b01,
    ST_ISSUE = 2'b11
  } twf_state_t;

  // One decoded instruction: kind, first word, operand literal, its address.
  typedef struct packed {
    twf_kind_t kind;
    logic [WORD_W-1:0] first;
    logic [LIT_W-1:0] literal;
    logic [PC_W-1:0] addr;
  } twf_op_t;

endpackage : twf_pkg

// *** twf_word_class.sv ***
// Combinational classifier of one fetched instruction word.
`timescale 1ns/1ps
`default_nettype none

module twf_word_class (
  input wire logic [twf_pkg::WORD_W-1:0] word, // Fetched instruction word.
  output logic is_operand, // Upper nibble is the operand prefix.
  output logic is_two_word, // Word opens a two-word instruction.
  output twf_pkg::twf_kind_t kind, // Kind of instruction the word opens.
  output logic [twf_pkg::PC_W-1:0] branch_ofs // Branch offset in bytes.
);

  // Operand words are recognised by their prefix alone.
  assign is_operand = (word[15:12] == twf_pkg::OPERAND_PREFIX);

  // Exactly four opcodes open a two-word instruction.
  always_comb begin
    kind = twf_pkg::K_SINGLE;
    is_two_word = 1'b0;
    if (word[15:8] == twf_pkg::GOTO_OPC) begin
      kind = twf_pkg::K_GOTO;
      is_two_word = 1'b1;
    end else if (word[15:9] == twf_pkg::CALL_OPC) begin
      kind = twf_pkg::K_CALL;
      is_two_word = 1'b1;
    end else if (word[15:12] == twf_pkg::FILE_MOVE_OPC) begin
      kind = twf_pkg::K_FILE_MOVE;
      is_two_word = 1'b1;
    end else if (word[15:8] == twf_pkg::PTR_LOAD_OPC) begin
      kind = twf_pkg::K_PTR_LOAD;
      is_two_word = 1'b1;
    end else if (word[15:11] == twf_pkg::BRA_OPC) begin
      kind = twf_pkg::K_BRANCH;
    end else if (is_operand) begin
      kind = twf_pkg::K_NOP_OPERAND;
    end
  end

  // The offset counts words, so it is sign extended and doubled to bytes.
  assign branch_ofs = {{(twf_pkg::PC_W - twf_pkg::BRA_OFS_W - 1)
                        {word[twf_pkg::BRA_OFS_W-1]}},
                       word[twf_pkg::BRA_OFS_W-1:0], 1'b0};

endmodule : twf_word_class
`default_nettype wire

// *** twf_fetch_asserts.sv ***
// Checker of the two-word fetch block's port behaviour.
`timescale 1ns/1ps
`default_nettype none

module twf_fetch_asserts (
  input wire logic ref_clk, // Core clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic pm_req, // Fetch request.
  input wire logic [twf_pkg::PC_W-1:0] pm_addr, // Fetch address.
  input wire logic [twf_pkg::WORD_W-1:0] pm_data, // Fetched word.
  input wire logic pm_valid, // Word valid.
  input wire logic skip_req, // Skip request.
  input wire logic core_ready, // Op taken.
  input wire logic op_valid, // Op offered.
  input wire twf_pkg::twf_op_t op, // Offered op.
  input wire logic [twf_pkg::PC_W-1:0] pc, // Next fetch address.
  input wire logic two_word_pending // First word held.
);
  // One clock domain, so clock and reset are given once for all.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_align;
    pc[0] == 1'h0 && pm_addr[0] == 1'h0;
  endproperty
  a_align: assert property (p_align) else $error("odd address");
  property p_req_hold;
    pm_req && !pm_valid |=> pm_req && $stable(pm_addr);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("req moved");
  // A new op is judged in the first cycle it is offered.
  property p_single;
    $rose(op_valid) && op.kind == twf_pkg::K_SINGLE |->
      pc == op.addr + 21'h2;
  endproperty
  a_single: assert property (p_single) else $error("bad step");
  property p_jump;
    $rose(op_valid) && op.kind inside {twf_pkg::K_GOTO, twf_pkg::K_CALL}
      |-> pc == {op.literal, op.first[7:0], 1'h0};
  endproperty
  a_jump: assert property (p_jump) else $error("bad target");
  property p_branch;
    $rose(op_valid) && op.kind == twf_pkg::K_BRANCH |->
      pc == op.addr + 21'h2 + {{9{op.first[10]}}, op.first[10:0], 1'h0};
  endproperty
  a_branch: assert property (p_branch) else $error("bad branch");
  property p_literal;
    $rose(op_valid) && op.kind inside {twf_pkg::K_GOTO, twf_pkg::K_CALL,
      twf_pkg::K_FILE_MOVE, twf_pkg::K_PTR_LOAD} |->
      op.literal == $past(pm_data[11:0]) && $past(pm_data[15:12]) == 4'hF;
  endproperty
  a_literal: assert property (p_literal) else $error("bad operand");
  property p_nop;
    $rose(op_valid) && op.first[15:12] == 4'hF |->
      op.kind == twf_pkg::K_NOP_OPERAND;
  endproperty
  a_nop: assert property (p_nop) else $error("lone word not nop");
  property p_pend;
    two_word_pending && pm_valid && pm_data[15:12] == 4'hF |=>
      !two_word_pending;
  endproperty
  a_pend: assert property (p_pend) else $error("pending stuck");
endmodule : twf_fetch_asserts

bind twf_fetch twf_fetch_asserts i_twf_fetch_asserts (
  .ref_clk(ref_clk), .rst_n(rst_n), .pm_req(pm_req), .pm_addr(pm_addr),
  .pm_data(pm_data), .pm_valid(pm_valid), .skip_req(skip_req),
  .core_ready(core_ready), .op_valid(op_valid), .op(op), .pc(pc),
  .two_word_pending(two_word_pending));
`default_nettype wire

// *** twf_pmem.sv ***
// Behavioural program memory that answers fetches after a set delay.
`timescale 1ns/1ps
`default_nettype none

module twf_pmem (
  input wire logic ref_clk, // Core clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic pm_req, // Fetch request.
  input wire logic [twf_pkg::PC_W-1:0] pm_addr, // Byte address.
  input wire logic [3:0] lat, // Idle cycles before the answer.
  output logic [twf_pkg::WORD_W-1:0] pm_data, // Fetched word.
  output logic pm_valid // One-cycle answer pulse.
);
  logic [twf_pkg::WORD_W-1:0] mem [0:255];
  logic [3:0] cnt;

  // One answer per request; between answers the data is inverted each
  // cycle so a read at the wrong moment sees a wrong word.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      pm_valid <= 1'h0;
      pm_data <= 16'h0000;
    end else if (pm_req && !pm_valid && cnt == lat) begin
      pm_valid <= 1'h1;
      pm_data <= mem[pm_addr[8:1]];
      cnt <= 4'h0;
    end else begin
      pm_valid <= 1'h0;
      pm_data <= ~pm_data;
      cnt <= (pm_req && !pm_valid) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : twf_pmem
`default_nettype wire

// *** tb_two_word_instruction_fetch.sv ***
// Self-checking testbench of the two-word fetch block.
`timescale 1ns/1ps
`default_nettype none

module tb_two_word_instruction_fetch;
  logic ref_clk;
  logic rst_n;
  logic pm_req;
  logic [twf_pkg::PC_W-1:0] pm_addr;
  logic [twf_pkg::WORD_W-1:0] pm_data;
  logic pm_valid;
  logic skip_req;
  logic core_ready;
  logic op_valid;
  twf_pkg::twf_op_t op;
  logic [twf_pkg::PC_W-1:0] pc;
  logic two_word_pending;
  logic [3:0] lat;
  int failures;
  int checks;

  twf_fetch i_twf_fetch (
    .ref_clk(ref_clk), .rst_n(rst_n), .pm_req(pm_req), .pm_addr(pm_addr),
    .pm_data(pm_data), .pm_valid(pm_valid), .skip_req(skip_req),
    .core_ready(core_ready), .op_valid(op_valid), .op(op), .pc(pc),
    .two_word_pending(two_word_pending));
  twf_pmem i_twf_pmem (
    .ref_clk(ref_clk), .rst_n(rst_n), .pm_req(pm_req), .pm_addr(pm_addr),
    .lat(lat), .pm_data(pm_data), .pm_valid(pm_valid));

  // Core clock of 100 ns period.
  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Comparison of a decoded op.
  task automatic chk_op(input twf_pkg::twf_op_t got,
      input twf_pkg::twf_op_t exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_op

  // Comparison of a fetch address.
  task automatic chk_pc(input logic [20:0] got, input logic [20:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_pc

  // Comparison of a single-bit status output.
  task automatic chk_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_flag

  // Waits for the next op, judges it, then takes it a cycle later.
  task automatic take_op(input twf_pkg::twf_kind_t k, input logic [15:0] f,
      input logic [11:0] l, input logic [20:0] a, input logic [20:0] p,
      input logic skip);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (op_valid !== 1'h1 && n < 60);
    chk_flag(op_valid, 1'h1);
    chk_flag(two_word_pending, 1'h0);
    chk_op(op, twf_pkg::twf_op_t'{k, f, l, a});
    chk_pc(pc, p);
    @(posedge ref_clk);
    core_ready <= 1'h1;
    skip_req <= skip;
    @(posedge ref_clk);
    core_ready <= 1'h0;
    skip_req <= 1'h0;
  endtask : take_op

  task automatic t_reset();
    repeat (2) @(posedge ref_clk);
    chk_pc(pc, twf_pkg::PC_RESET);
    rst_n <= 1'h1;
    $display("reset done");
  endtask : t_reset

  task automatic t_plain();
    take_op(twf_pkg::K_SINGLE, 16'h0F55, 12'hF55, 21'h0, 21'h2, 1'h0);
    take_op(twf_pkg::K_NOP_OPERAND, 16'hF123, 12'h123, 21'h2, 21'h4,
      1'h0);
    $display("plain done");
  endtask : t_plain

  task automatic t_pairs();
    take_op(twf_pkg::K_FILE_MOVE, 16'hC123, 12'h456, 21'h4, 21'h8,
      1'h0);
    take_op(twf_pkg::K_PTR_LOAD, 16'hEE12, 12'h034, 21'h8, 21'hC,
      1'h0);
    take_op(twf_pkg::K_CALL, 16'hEC20, 12'h000, 21'hC, 21'h40, 1'h0);
    $display("pairs done");
  endtask : t_pairs

  // Slow memory here; the skipped first word leaves its operand alone.
  task automatic t_skip();
    lat <= 4'h3;
    take_op(twf_pkg::K_SINGLE, 16'h1234, 12'h234, 21'h40, 21'h42,
      1'h1);
    take_op(twf_pkg::K_NOP_OPERAND, 16'hF222, 12'h222, 21'h44, 21'h46,
      1'h0);
    $display("skip done");
  endtask : t_skip

  task automatic t_jumps();
    lat <= 4'h0;
    take_op(twf_pkg::K_BRANCH, 16'hD005, 12'h005, 21'h46, 21'h52,
      1'h0);
    take_op(twf_pkg::K_GOTO, 16'hEF30, 12'h000, 21'h52, 21'h60, 1'h0);
    $display("jumps done");
  endtask : t_jumps

  // A first word followed by a plain word, then a backward branch.
  task automatic t_broken();
    take_op(twf_pkg::K_SINGLE, 16'h0ABC, 12'hABC, 21'h62, 21'h64,
      1'h0);
    take_op(twf_pkg::K_BRANCH, 16'hD7FD, 12'h7FD, 21'h64, 21'h60,
      1'h0);
    $display("broken pair done");
  endtask : t_broken

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // Program image in word slots, then the scenarios in fetch order.
  initial begin
    failures = 0;
    checks = 0;
    rst_n = 1'h0;
    skip_req = 1'h0;
    core_ready = 1'h0;
    lat = 4'h0;
    for (int i = 0; i < 256; i++) begin
      i_twf_pmem.mem[i] = 16'h0000;
    end
    i_twf_pmem.mem[0] = 16'h0F55;
    i_twf_pmem.mem[1] = 16'hF123;
    i_twf_pmem.mem[2] = 16'hC123;
    i_twf_pmem.mem[3] = 16'hF456;
    i_twf_pmem.mem[4] = 16'hEE12;
    i_twf_pmem.mem[5] = 16'hF034;
    i_twf_pmem.mem[6] = 16'hEC20;
    i_twf_pmem.mem[7] = 16'hF000;
    i_twf_pmem.mem[32] = 16'h1234;
    i_twf_pmem.mem[33] = 16'hC111;
    i_twf_pmem.mem[34] = 16'hF222;
    i_twf_pmem.mem[35] = 16'hD005;
    i_twf_pmem.mem[41] = 16'hEF30;
    i_twf_pmem.mem[42] = 16'hF000;
    i_twf_pmem.mem[48] = 16'hC333;
    i_twf_pmem.mem[49] = 16'h0ABC;
    i_twf_pmem.mem[50] = 16'hD7FD;
    t_reset();
    t_plain();
    t_pairs();
    t_skip();
    t_jumps();
    t_broken();
    wrap_up();
  end

  // The run needs some 90 cycles; 2000 cycles means a hang.
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
endmodule : tb_two_word_instruction_fetch
`default_nettype wire
